// ===== trf_pkg.sv
// constants and carrier types of the temperature result formatter
`default_nettype none
package trf_pkg;
  // ************************************************************
  // result formats
  // ************************************************************
  localparam int RES_W = 11;
  localparam int BYTE_W = 8;
  localparam int LO_BITS = 3;
  localparam int TEMP_W = 13;
  localparam int EXTRA_FRAC = 2;
  localparam int RAW_W = TEMP_W + EXTRA_FRAC;
  localparam int NUM_EXT = 2;
  localparam int NUM_CH = 3;
  localparam logic signed [TEMP_W-1:0] T_MINUS64 = 13'sh1E00;
  localparam logic signed [TEMP_W-1:0] T_PLUS128 = 13'sh0400;
  localparam logic signed [TEMP_W-1:0] T_PLUS191_875 = 13'sh05FF;
  localparam logic signed [TEMP_W-1:0] T_OFFSET64 = 13'sh0200;
  localparam logic [RES_W-1:0] LEG_MIN = 11'h600;
  localparam logic [RES_W-1:0] LEG_MAX = 11'h3FF;
  localparam logic [RES_W-1:0] EXT_MIN = 11'h400;
  localparam logic [RES_W-1:0] EXT_MAX = 11'h3FF;
  localparam logic [RES_W-1:0] FAULT_CODE = 11'h400;
  localparam logic [1:0] CH_INT = 2'h0;
  localparam logic [1:0] CH_EXT1 = 2'h1;
  localparam logic [1:0] CH_EXT2 = 2'h2;
  // ************************************************************
  // register map, register indices (byte address bits 6:2)
  // ************************************************************
  localparam int ADDR_W = 7;
  localparam logic [4:0] IDX_LEG_HI0 = 5'h00;
  localparam logic [4:0] IDX_LEG_LO0 = 5'h01;
  localparam logic [4:0] IDX_LEG_HI1 = 5'h02;
  localparam logic [4:0] IDX_LEG_LO1 = 5'h03;
  localparam logic [4:0] IDX_LEG_HI2 = 5'h04;
  localparam logic [4:0] IDX_LEG_LO2 = 5'h05;
  localparam logic [4:0] IDX_EXT_HI1 = 5'h06;
  localparam logic [4:0] IDX_EXT_LO1 = 5'h07;
  localparam logic [4:0] IDX_EXT_HI2 = 5'h08;
  localparam logic [4:0] IDX_EXT_LO2 = 5'h09;
  localparam logic [4:0] IDX_CONFIG2 = 5'h0A;
  localparam logic [4:0] IDX_BETA1 = 5'h0B;
  localparam logic [4:0] IDX_BETA2 = 5'h0C;
  localparam logic [4:0] IDX_IDEAL1 = 5'h0D;
  localparam logic [4:0] IDX_IDEAL2 = 5'h0E;
  localparam logic [4:0] IDX_STATUS = 5'h0F;
  localparam logic [4:0] IDX_MASK = 5'h10;
  localparam int CFG2_REC_BIT = 0;
  localparam logic [7:0] CFG2_RESET = 8'h01;
  localparam logic [7:0] BETA_OFF = 8'h07;
  localparam logic [7:0] BETA_RESET = 8'h00;
  localparam int ST_W = 3;
  localparam int ST_FAULT1 = 0;
  localparam int ST_FAULT2 = 1;
  localparam int ST_DONE = 2;
  // ************************************************************
  // carriers
  // ************************************************************
  typedef struct packed {
    logic valid;
    logic [1:0] channel;
    logic signed [RAW_W-1:0] value;
  } trf_conv_t;
  typedef struct packed {
    logic rec_en;
    logic [NUM_EXT-1:0] beta_en;
    logic [NUM_EXT-1:0][BYTE_W-1:0] ideality;
  } trf_corr_t;
  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic [NUM_CH-1:0][RES_W-1:0] leg;
    logic [NUM_EXT-1:0][RES_W-1:0] ext;
    logic [BYTE_W-1:0] cfg2;
    logic [NUM_EXT-1:0][BYTE_W-1:0] beta;
    logic [NUM_EXT-1:0][BYTE_W-1:0] ideal;
    logic [ST_W-1:0] status;
    logic [ST_W-1:0] mask;
  } trf_state_t;
endpackage
`default_nettype wire

// ===== trf_sync.sv
// two-stage synchroniser for asynchronous level inputs
`timescale 1ns/1ps
`default_nettype none
module trf_sync #(
  parameter int WIDTH = 2
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge clock) begin
        if (reset) begin
          meta_q[i] <= 1'b0;
          sync_out[i] <= 1'b0;
        end else begin
          meta_q[i] <= async_in[i];
          sync_out[i] <= meta_q[i];
        end
      end
    end
  endgenerate
endmodule // trf_sync
`default_nettype wire

// ===== trf_format.sv
// converts one raw converter sample into legacy and extended codes
`timescale 1ns/1ps
`default_nettype none
module trf_format (
  input wire logic signed [trf_pkg::RAW_W-1:0] raw,
  input wire logic fault,
  output logic signed [trf_pkg::TEMP_W-1:0] temp,
  output logic [trf_pkg::RES_W-1:0] legacy,
  output logic [trf_pkg::RES_W-1:0] extended
);
  logic signed [trf_pkg::TEMP_W-1:0] shifted;
  // extra averaging bits are dropped, so sub-lsb noise never shows
  assign temp = raw[trf_pkg::RAW_W-1:trf_pkg::EXTRA_FRAC];
  assign shifted = temp - trf_pkg::T_OFFSET64;
  always_comb begin
    if (fault) begin
      legacy = trf_pkg::FAULT_CODE;
      extended = trf_pkg::FAULT_CODE;
    end else begin
      if (temp <= trf_pkg::T_MINUS64) begin
        legacy = trf_pkg::LEG_MIN;
      end else if (temp >= trf_pkg::T_PLUS128) begin
        legacy = trf_pkg::LEG_MAX;
      end else begin
        legacy = temp[trf_pkg::RES_W-1:0];
      end
      if (temp <= trf_pkg::T_MINUS64) begin
        extended = trf_pkg::EXT_MIN;
      end else if (temp >= trf_pkg::T_PLUS191_875) begin
        extended = trf_pkg::EXT_MAX;
      end else begin
        extended = shifted[trf_pkg::RES_W-1:0];
      end
    end
  end
endmodule // trf_format
`default_nettype wire

// ===== trf_top.sv
// result registers, corrections and avalon slave of the formatter
//
// Summary of operation
// - high byte holds result bits 10:3, low byte bits 7:5 hold bits 2:0.
// - extra converter resolution is truncated to an 11-bit result.
// - remote zones also get an extended result, offset by 64 degrees.
// - legacy and extended results live in separate registers, both updated.
// - legacy clamps to 600h at -64 and below, 3FFh at 128 and above.
// - extended maps 64 to zero, clamps 400h low and 3FFh high.
// - open or shorted positive pin sets fault status and forces 400h.
// - series resistance correction on unless its configuration bit is cleared.
// - writing 07h to a beta register turns beta compensation off.
// - fifth variant resets with beta compensation off on channel two.
// - ideality resets to the 1.008 code and is applied as programmed.
`timescale 1ns/1ps
`default_nettype none
module trf_top #(
  parameter bit FIFTH_VARIANT = 1'b0,
  // code standing for an ideality of 1.008, value arbitrary
  parameter logic [7:0] IDEALITY_DEFAULT = 8'h12
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic [trf_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire trf_pkg::trf_conv_t conv,
  input wire logic [trf_pkg::NUM_EXT-1:0] diode_positive_pin_fault,
  output trf_pkg::trf_corr_t corr,
  output logic irq
);
  // ************************************************************
  // state and helpers
  // ************************************************************
  trf_pkg::trf_state_t s_q;
  trf_pkg::trf_state_t s_d;
  logic [trf_pkg::NUM_EXT-1:0] fault_s;
  logic conv_fault;
  logic signed [trf_pkg::TEMP_W-1:0] temp;
  logic [trf_pkg::RES_W-1:0] fmt_leg;
  logic [trf_pkg::RES_W-1:0] fmt_ext;
  logic req;
  logic [4:0] idx;
  logic [trf_pkg::ST_W-1:0] st_set;
  logic [trf_pkg::ST_W-1:0] st_clr;
  logic [7:0] rd_byte;
  logic wr_go;

  trf_sync #(
    .WIDTH(trf_pkg::NUM_EXT)
  ) u_sync (
    .clock(clock),
    .reset(reset),
    .async_in(diode_positive_pin_fault),
    .sync_out(fault_s)
  );

  // internal zone has no pin, so it never reports a fault
  assign conv_fault = (conv.channel == trf_pkg::CH_EXT1) ? fault_s[0] :
                      (conv.channel == trf_pkg::CH_EXT2) ? fault_s[1] :
                      1'b0;

  trf_format u_format (
    .raw(conv.value),
    .fault(conv_fault),
    .temp(temp),
    .legacy(fmt_leg),
    .extended(fmt_ext)
  );

  assign req = avs_read | avs_write;
  assign idx = avs_address[trf_pkg::ADDR_W-1:2];
  assign wr_go = avs_write & s_q.ack & avs_byteenable[0];
  // one wait state: readdata is prepared in the first request cycle
  assign avs_waitrequest = req & ~s_q.ack;
  assign avs_readdata = s_q.rdata;

  // ************************************************************
  // read multiplexer
  // ************************************************************
  always_comb begin
    rd_byte = 8'h00;
    unique case (idx)
      trf_pkg::IDX_LEG_HI0: rd_byte = s_q.leg[0][10:3];
      trf_pkg::IDX_LEG_LO0: rd_byte = {s_q.leg[0][2:0], 5'h00};
      trf_pkg::IDX_LEG_HI1: rd_byte = s_q.leg[1][10:3];
      trf_pkg::IDX_LEG_LO1: rd_byte = {s_q.leg[1][2:0], 5'h00};
      trf_pkg::IDX_LEG_HI2: rd_byte = s_q.leg[2][10:3];
      trf_pkg::IDX_LEG_LO2: rd_byte = {s_q.leg[2][2:0], 5'h00};
      trf_pkg::IDX_EXT_HI1: rd_byte = s_q.ext[0][10:3];
      trf_pkg::IDX_EXT_LO1: rd_byte = {s_q.ext[0][2:0], 5'h00};
      trf_pkg::IDX_EXT_HI2: rd_byte = s_q.ext[1][10:3];
      trf_pkg::IDX_EXT_LO2: rd_byte = {s_q.ext[1][2:0], 5'h00};
      trf_pkg::IDX_CONFIG2: rd_byte = s_q.cfg2;
      trf_pkg::IDX_BETA1: rd_byte = s_q.beta[0];
      trf_pkg::IDX_BETA2: rd_byte = s_q.beta[1];
      trf_pkg::IDX_IDEAL1: rd_byte = s_q.ideal[0];
      trf_pkg::IDX_IDEAL2: rd_byte = s_q.ideal[1];
      trf_pkg::IDX_STATUS: rd_byte = {5'h00, s_q.status};
      trf_pkg::IDX_MASK: rd_byte = {5'h00, s_q.mask};
      default: rd_byte = 8'h00;
    endcase
  end

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    s_d = s_q;
    st_set = '0;
    st_clr = '0;
    s_d.ack = req & ~s_q.ack;
    if (avs_read && !s_q.ack) begin
      s_d.rdata = {24'h000000, rd_byte};
    end
    if (wr_go) begin
      unique case (idx)
        trf_pkg::IDX_CONFIG2: s_d.cfg2 = avs_writedata[7:0];
        trf_pkg::IDX_BETA1: s_d.beta[0] = avs_writedata[7:0];
        trf_pkg::IDX_BETA2: s_d.beta[1] = avs_writedata[7:0];
        trf_pkg::IDX_IDEAL1: s_d.ideal[0] = avs_writedata[7:0];
        trf_pkg::IDX_IDEAL2: s_d.ideal[1] = avs_writedata[7:0];
        trf_pkg::IDX_STATUS: st_clr = avs_writedata[trf_pkg::ST_W-1:0];
        trf_pkg::IDX_MASK: s_d.mask = avs_writedata[trf_pkg::ST_W-1:0];
        default: st_clr = '0;
      endcase
    end
    if (conv.valid) begin
      // whole 11-bit word updated at once, high and low byte reads are not locked together
      unique case (conv.channel)
        trf_pkg::CH_INT: s_d.leg[0] = fmt_leg;
        trf_pkg::CH_EXT1: begin
          s_d.leg[1] = fmt_leg;
          s_d.ext[0] = fmt_ext;
          st_set[trf_pkg::ST_FAULT1] = conv_fault;
        end
        trf_pkg::CH_EXT2: begin
          s_d.leg[2] = fmt_leg;
          s_d.ext[1] = fmt_ext;
          st_set[trf_pkg::ST_FAULT2] = conv_fault;
        end
        default: st_set = '0;
      endcase
      st_set[trf_pkg::ST_DONE] = 1'b1;
    end
    // a new event in the clearing cycle survives the clear
    s_d.status = (s_q.status & ~st_clr) | st_set;
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      s_q <= '0;
      s_q.cfg2 <= trf_pkg::CFG2_RESET;
      s_q.beta[0] <= trf_pkg::BETA_RESET;
      s_q.beta[1] <= FIFTH_VARIANT ? trf_pkg::BETA_OFF
                                   : trf_pkg::BETA_RESET;
      s_q.ideal[0] <= IDEALITY_DEFAULT;
      s_q.ideal[1] <= IDEALITY_DEFAULT;
    end else begin
      s_q <= s_d;
    end
  end

  // ************************************************************
  // outputs to the analog front end
  // ************************************************************
  assign corr.rec_en = s_q.cfg2[trf_pkg::CFG2_REC_BIT];
  assign corr.beta_en[0] = s_q.beta[0] != trf_pkg::BETA_OFF;
  assign corr.beta_en[1] = s_q.beta[1] != trf_pkg::BETA_OFF;
  assign corr.ideality = s_q.ideal;
  assign irq = |(s_q.status & s_q.mask);

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  sequence ext1_ok_s;
    conv.valid && conv.channel == trf_pkg::CH_EXT1 && !fault_s[0];
  endsequence
  sequence wr_accept_s(logic [4:0] r);
    avs_write && !avs_waitrequest && avs_byteenable[0] && idx == r;
  endsequence

  leg_clamp_low_a: assert property (
    ext1_ok_s and (temp <= trf_pkg::T_MINUS64)
    |=> s_q.leg[1] == 11'h600)
    else $error("legacy low clamp wrong");
  leg_sat_high_a: assert property (
    ext1_ok_s and (temp >= trf_pkg::T_PLUS128)
    |=> s_q.leg[1] == 11'h3FF)
    else $error("legacy high saturation wrong");
  ext_clamp_a: assert property (
    ext1_ok_s and (temp <= trf_pkg::T_MINUS64)
    |=> s_q.ext[0] == 11'h400 && s_q.leg[1] == 11'h600)
    else $error("extended low clamp wrong");
  ext_zero_at64_a: assert property (
    ext1_ok_s and (temp == trf_pkg::T_OFFSET64)
    |=> s_q.ext[0] == 11'h000 && s_q.leg[1] == 11'h200)
    else $error("extended offset wrong");
  both_formats_a: assert property (
    ext1_ok_s |=> s_q.leg[1] == $past(fmt_leg)
      && s_q.ext[0] == $past(fmt_ext))
    else $error("formats not updated together");
  fault_code_a: assert property (
    conv.valid && conv.channel == trf_pkg::CH_EXT2 && fault_s[1]
    |=> s_q.leg[2] == 11'h400 && s_q.ext[1] == 11'h400
      && s_q.status[trf_pkg::ST_FAULT2])
    else $error("fault code or status missing");
  rec_clear_a: assert property (
    wr_accept_s(trf_pkg::IDX_CONFIG2) ##0
      !avs_writedata[trf_pkg::CFG2_REC_BIT] |=> !corr.rec_en)
    else $error("resistance correction still on");
  beta_off_a: assert property (
    wr_accept_s(trf_pkg::IDX_BETA1) ##0 avs_writedata[7:0] == 8'h07
    |=> !corr.beta_en[0] [*2] or ##1 wr_go)
    else $error("beta compensation not turned off");
  reset_values_a: assert property (disable iff (1'b0)
    reset |=> corr.beta_en[1] == !FIFTH_VARIANT
      && corr.ideality[0] == IDEALITY_DEFAULT && corr.rec_en)
    else $error("wrong reset value of corrections");
  lo_byte_read_a: assert property (
    avs_read && avs_waitrequest && idx == trf_pkg::IDX_LEG_LO0
    ##1 !avs_waitrequest
    |-> avs_readdata[7:5] == $past(s_q.leg[0][2:0])
      && avs_readdata[4:0] == 5'h00)
    else $error("low byte layout wrong");

  // ************************************************************
  // result checks
  // ************************************************************
  sequence ext2_ok_s;
    conv.valid && conv.channel == trf_pkg::CH_EXT2 && !fault_s[1];
  endsequence

  ext_sat_high_a: assert property (
    ext1_ok_s and (temp >= trf_pkg::T_PLUS191_875)
    |=> s_q.ext[0] == trf_pkg::EXT_MAX)
    else $error("extended high saturation wrong");
  ext_offset_a: assert property (
    ext1_ok_s and (temp > trf_pkg::T_MINUS64)
      and (temp < trf_pkg::T_PLUS128)
    |=> s_q.ext[0] == s_q.leg[1] - 11'(trf_pkg::T_OFFSET64))
    else $error("extended not legacy minus offset");
  leg_trunc_a: assert property (
    ext1_ok_s and (temp > trf_pkg::T_MINUS64)
      and (temp < trf_pkg::T_PLUS128)
    |=> s_q.leg[1] == 11'($past(conv.value) >>> trf_pkg::EXTRA_FRAC))
    else $error("fraction bits not truncated");
  fault_ext1_a: assert property (
    conv.valid && conv.channel == trf_pkg::CH_EXT1 && fault_s[0]
    |=> s_q.leg[1] == trf_pkg::FAULT_CODE
      && s_q.ext[0] == trf_pkg::FAULT_CODE && s_q.status[trf_pkg::ST_FAULT1])
    else $error("first zone fault code or status missing");
  ext2_clamp_a: assert property (
    ext2_ok_s and (temp <= trf_pkg::T_MINUS64)
    |=> s_q.leg[2] == trf_pkg::LEG_MIN && s_q.ext[1] == trf_pkg::EXT_MIN)
    else $error("second zone low clamp wrong");
  leg2_sat_a: assert property (
    ext2_ok_s and (temp >= trf_pkg::T_PLUS128)
    |=> s_q.leg[2] == trf_pkg::LEG_MAX)
    else $error("second zone legacy saturation wrong");
  int_no_ext_a: assert property (
    conv.valid && conv.channel == trf_pkg::CH_INT
    |=> $stable(s_q.ext) && $stable(s_q.leg[2:1]))
    else $error("internal sample touched a remote result");
  chan3_ignored_a: assert property (
    conv.valid && conv.channel == 2'h3
    |=> $stable(s_q.leg) && $stable(s_q.ext))
    else $error("unused channel changed a result");
  // results move only on a sample, so a byte pair tears only if a sample lands between its two reads
  result_hold_a: assert property (
    !conv.valid |=> $stable(s_q.leg) && $stable(s_q.ext))
    else $error("result changed without a sample");
  done_flag_a: assert property (
    conv.valid |=> s_q.status[trf_pkg::ST_DONE])
    else $error("done flag lost against a clear");

  // ************************************************************
  // bus checks
  // ************************************************************
  one_wait_a: assert property (
    req && avs_waitrequest |=> !avs_waitrequest)
    else $error("more than one wait state");
  rdata_hold_a: assert property (
    avs_read && !avs_waitrequest |=> $stable(avs_readdata))
    else $error("read data moved after the read");
  status_clear_a: assert property (
    wr_accept_s(trf_pkg::IDX_STATUS) ##0 !conv.valid
    |=> (s_q.status & $past(avs_writedata[trf_pkg::ST_W-1:0])) == '0)
    else $error("status bit not cleared");
  mask_write_a: assert property (
    wr_accept_s(trf_pkg::IDX_MASK)
    |=> s_q.mask == $past(avs_writedata[trf_pkg::ST_W-1:0]))
    else $error("mask write not applied");
  ideal_write_a: assert property (
    wr_accept_s(trf_pkg::IDX_IDEAL1)
    |=> corr.ideality[0] == $past(avs_writedata[trf_pkg::BYTE_W-1:0]))
    else $error("ideality write not applied");
  beta2_on_a: assert property (
    wr_accept_s(trf_pkg::IDX_BETA2) ##0
      avs_writedata[trf_pkg::BYTE_W-1:0] != trf_pkg::BETA_OFF
    |=> corr.beta_en[1])
    else $error("beta compensation not turned on");
  // the low byte lane carries every control, without it nothing moves
  be_ignore_a: assert property (
    avs_write && !avs_waitrequest && !avs_byteenable[0]
    |=> $stable(s_q.cfg2) && $stable(s_q.beta) && $stable(s_q.ideal)
      && $stable(s_q.mask))
    else $error("write without byte lane took effect");
endmodule // trf_top
`default_nettype wire

// ===== trf_diode_model.sv
// partner model: remote diode front end delivering converter samples
`timescale 1ns/1ps
`default_nettype none
module trf_diode_model (
  input wire logic clock,
  input wire logic reset,
  input wire logic go,
  input wire logic [1:0] channel,
  input wire logic signed [trf_pkg::RAW_W-1:0] temp_raw,
  input wire logic [trf_pkg::NUM_EXT-1:0] pin_open,
  output var trf_pkg::trf_conv_t conv,
  output wire logic [trf_pkg::NUM_EXT-1:0] pin_fault
);
  // ************************************************************
  // sample delivery
  // ************************************************************
  // between samples the value toggles so a stale word is never trusted
  always_ff @(posedge clock) begin
    if (reset) begin
      conv <= '0;
    end else begin
      conv.valid <= go;
      conv.channel <= channel;
      conv.value <= go ? temp_raw : ~conv.value;
    end
  end
  // comparator output, not aligned to the clock
  assign pin_fault = pin_open;
endmodule // trf_diode_model
`default_nettype wire

// ===== test_temperature_result_formatter.sv
// self-checking bench of the temperature result formatter
`timescale 1ns/1ps
`default_nettype none
module test_temperature_result_formatter;
  logic clock, reset, avs_read, avs_write, avs_waitrequest, irq, go;
  logic [6:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rdv;
  logic [3:0] avs_byteenable;
  logic [1:0] channel, pin_open, pin_fault;
  logic signed [14:0] temp_raw;
  trf_pkg::trf_conv_t conv;
  trf_pkg::trf_corr_t corr, corr5;
  int fail_count, cmp_count, i;
  logic [14:0] raws [10] = '{15'h7740, 15'h7800, 15'h7FFF, 15'h0003,
    15'h0800, 15'h0FFC, 15'h1000, 15'h17F8, 15'h17FC, 15'h1900};
  trf_top dut (.clock(clock), .reset(reset), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .conv(conv), .diode_positive_pin_fault(pin_fault), .corr(corr),
    .irq(irq));
  trf_top #(.FIFTH_VARIANT(1'b1)) dut5 (.clock(clock), .reset(reset),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(),
    .avs_waitrequest(), .conv(conv), .diode_positive_pin_fault(pin_fault),
    .corr(corr5), .irq());
  trf_diode_model model (.clock(clock), .reset(reset), .go(go),
    .channel(channel), .temp_raw(temp_raw), .pin_open(pin_open),
    .conv(conv), .pin_fault(pin_fault));
  // ************************************************************
  // helpers
  // ************************************************************
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  initial begin
    repeat (20000) @(posedge clock);
    fail_count++;
    report_and_stop();
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  // request held until waitrequest is seen low at a rising edge
  task automatic bus(logic wr, logic [6:0] a, logic [31:0] d, logic [3:0] be);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_read <= !wr;
    avs_write <= wr;
    do begin
      @(posedge clock);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    rdv = avs_readdata;
    if (n >= 50) chk("waitrequest", 32'h0, 32'h1);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clock);
  endtask
  task automatic wr(logic [6:0] a, logic [7:0] d);
    bus(1'b1, a, {24'h0, d}, 4'hF);
  endtask
  task automatic rd(logic [6:0] a, logic [7:0] e);
    bus(1'b0, a, 32'h0, 4'hF);
    chk($sformatf("reg %h", a), {24'h0, e}, rdv);
  endtask
  task automatic convert(logic [1:0] c, logic [14:0] r);
    go <= 1'b1;
    channel <= c;
    temp_raw <= r;
    @(posedge clock);
    go <= 1'b0;
    repeat (2) @(posedge clock);
  endtask
  // expected codes worked out from the clamping rules
  task automatic chk_res(logic [1:0] c, logic signed [14:0] r);
    logic signed [12:0] t;
    logic [10:0] l, x;
    t = 13'(r >>> 2);
    l = t <= trf_pkg::T_MINUS64 ? 11'h600 :
      t >= trf_pkg::T_PLUS128 ? 11'h3FF : t[10:0];
    x = t <= trf_pkg::T_MINUS64 ? 11'h400 :
      t >= trf_pkg::T_PLUS191_875 ? 11'h3FF : 11'(t - trf_pkg::T_OFFSET64);
    convert(c, r);
    rd(7'(c) << 3, l[10:3]);
    rd((7'(c) << 3) + 7'h04, {l[2:0], 5'h00});
    if (c != 2'h0) begin
      rd(7'h10 + (7'(c) << 3), x[10:3]);
      rd(7'h14 + (7'(c) << 3), {x[2:0], 5'h00});
    end
  endtask
  // ************************************************************
  // tests
  // ************************************************************
  initial begin
    {avs_read, avs_write, go, pin_open, channel} = '0;
    {avs_address, avs_writedata, temp_raw} = '0;
    avs_byteenable = 4'hF;
    reset = 1'b1;
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    repeat (3) @(posedge clock);
    rd(7'h28, 8'h01);
    rd(7'h2C, 8'h00);
    rd(7'h30, 8'h00);
    rd(7'h34, 8'h12);
    rd(7'h3C, 8'h00);
    chk("corr", {13'h0, 1'b1, 2'b11, 16'h1212}, {13'h0, corr});
    chk("beta_en fifth", 32'h1, {30'h0, corr5.beta_en});
    $display("test reset values done");
    for (i = 0; i < 10; i++) chk_res(2'(1 + i % 2), raws[i]);
    chk_res(2'h0, 15'h0FFC);
    $display("test formats done");
    rd(7'h3C, 8'h04);
    chk("irq", 32'h0, {31'h0, irq});
    wr(7'h40, 8'h04);
    chk("irq", 32'h1, {31'h0, irq});
    wr(7'h3C, 8'h04);
    chk("irq", 32'h0, {31'h0, irq});
    rd(7'h3C, 8'h00);
    // a sample landing on the clearing write keeps its done flag
    go <= 1'b1;
    channel <= 2'h0;
    temp_raw <= 15'h0000;
    fork
      wr(7'h3C, 8'h04);
      begin
        @(posedge clock);
        go <= 1'b0;
      end
    join
    rd(7'h3C, 8'h04);
    $display("test interrupt done");
    pin_open <= 2'b11;
    wr(7'h40, 8'h02);
    repeat (4) @(posedge clock);
    convert(2'h2, 15'h0800);
    convert(2'h1, 15'h0800);
    convert(2'h0, 15'h0800);
    rd(7'h10, 8'h80);
    rd(7'h14, 8'h00);
    rd(7'h20, 8'h80);
    rd(7'h08, 8'h80);
    rd(7'h18, 8'h80);
    rd(7'h00, 8'h40);
    rd(7'h3C, 8'h07);
    chk("irq", 32'h1, {31'h0, irq});
    pin_open <= 2'b00;
    repeat (4) @(posedge clock);
    wr(7'h3C, 8'h07);
    chk_res(2'h2, 15'h0800);
    rd(7'h3C, 8'h04);
    chk("irq", 32'h0, {31'h0, irq});
    $display("test fault done");
    convert(2'h3, 15'h1000);
    rd(7'h10, 8'h40);
    wr(7'h28, 8'h00);
    wr(7'h2C, 8'h07);
    wr(7'h30, 8'h05);
    wr(7'h34, 8'h5A);
    bus(1'b1, 7'h38, 32'hA5, 4'h0);
    rd(7'h38, 8'h12);
    rd(7'h44, 8'h00);
    chk("corr", {13'h0, 1'b0, 2'b10, 16'h125A}, {13'h0, corr});
    $display("test controls done");
    report_and_stop();
  end
endmodule // test_temperature_result_formatter
`default_nettype wire
